/* design/scoc_pkg.sv */
// Package: constants for the switch capability object codec
package scoc_pkg;
   // ****************************************
   // Register map (APB byte addresses)
   // ****************************************
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_NS_FLAGS  = 8'h04;
   localparam logic [7:0] REG_NS_VEND   = 8'h08;
   localparam logic [7:0] REG_FC_FLAGS  = 8'h0c;
   localparam logic [7:0] REG_FC_VEND   = 8'h10;
   localparam logic [7:0] REG_CFG_FLAGS = 8'h14;
   localparam logic [7:0] REG_ZN_FLAGS  = 8'h18;
   localparam logic [7:0] REG_STATUS    = 8'h1c;
   localparam logic [7:0] REG_RX_NS     = 8'h20;
   localparam logic [7:0] REG_RX_NSV    = 8'h24;
   localparam logic [7:0] REG_RX_FC     = 8'h28;
   localparam logic [7:0] REG_RX_FCV    = 8'h2c;
   localparam logic [7:0] REG_RX_CFG    = 8'h30;
   localparam logic [7:0] REG_RX_ZN     = 8'h34;
   localparam logic [7:0] REG_RX_UNK    = 8'h38;
   localparam logic [7:0] REG_RX_LAST   = 8'h3c;

   // ****************************************
   // Object identifiers
   // ****************************************
   localparam logic [7:0] NS_TYPE   = 8'hfc;
   localparam logic [7:0] NS_SUB    = 8'h02;
   localparam logic [7:0] FC_TYPE   = 8'hfd;
   localparam logic [7:0] FC_SUB    = 8'h00;
   localparam logic [7:0] CFG_TYPE  = 8'hfa;
   localparam logic [7:0] CFG_SUB   = 8'h01;
   localparam logic [7:0] ZN_TYPE   = 8'hfa;
   localparam logic [7:0] ZN_SUB    = 8'h03;
   localparam logic [7:0] ONE_ENTRY = 8'h01;
   localparam logic [7:0] RESV_BYTE = 8'h00;

   // ****************************************
   // Valid flag masks (reserved bits cleared)
   // ****************************************
   localparam logic [31:0] NS_MASK  = 32'h0000_001f;
   localparam logic [31:0] FC_MASK  = 32'h0000_0001;
   localparam logic [31:0] CFG_MASK = 32'h0000_000f;
   localparam logic [31:0] ZN_MASK  = 32'h0000_03ff;

   // ****************************************
   // Layout
   // ****************************************
   localparam logic [3:0] OBJ_BYTES = 4'hc;
   localparam logic [3:0] HDR_BYTES = 4'h4;
   localparam logic [2:0] ENT_LAST  = 3'h7;
   localparam int         NUM_OBJ   = 4;

   // CTRL fields
   localparam int CTRL_TX_GO = 0;
   localparam int CTRL_RX_CLR = 1;

   typedef enum logic [1:0] {
      OBJ_NS,
      OBJ_FC,
      OBJ_CFG,
      OBJ_ZN
   } scoc_obj_type;
endpackage : scoc_pkg

/* design/scoc_codec.sv */
// Module: capability object builder and parser for switch support exchange
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// RULE1 - Object header: type byte, subtype byte, reserved byte, entry count byte.
// RULE2 - Every entry after the header is exactly eight bytes.
// RULE3 - Interconnect element information object always present; framed outside this block.
// RULE4 - Name-server object is type FCh subtype 02h, standard then vendor word.
// RULE5 - Name-server bits 0..3 advertise entry object formats 00h..03h.
// RULE6 - Name-server bit 4 tolerates zero-length query accept; 5..31 reserved.
// RULE7 - Name-server vendor word passed through uninterpreted.
// RULE8 - Fabric-controller object is type FDh subtype 00h, standard then vendor word.
// RULE9 - Fabric-controller bit 0 accepts state-change notices; 1..31 reserved.
// RULE10 - Config-server object is type FAh subtype 01h, flags then reserved word.
// RULE11 - Config-server bits 0..3 give supported command classes; rest reserved.
// RULE12 - Zone-server object is type FAh subtype 03h, flags then reserved word.
// RULE13 - Zoning bit 0 enhanced possible, bit 1 enhanced active.
// RULE14 - Zoning bit 2 one in restrict mode, zero in allow mode.
// RULE15 - Zoning bit 3 one when default-zone traffic denied.
// RULE16 - Zoning bits 4,5 database able and database kept.
// RULE17 - Zoning bit 6 direct activation, bit 7 hard zoning.
// RULE18 - Zoning bits 8,9 security zoning support and enable; rest reserved.
// RULE19 - Enclosing payload length is a multiple of four, excluding leading words.
// RULE20 - Enclosing payload revision is 01h.
// RULE21 - Reserved sent zero, ignored on receive; flag words sent MSB first.
// RULE22 - Parser walks by entry count, flags unknown objects, skips their entries.
module scoc_codec (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [7:0]       tx_data,
   output logic             tx_valid,
   output logic             tx_last,
   input  wire logic        tx_ready,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_valid,
   input  wire logic        rx_last,
   output logic             rx_ready
);
   // ****************************************
   // Register file
   // ****************************************
   logic [31:0] ns_flags_r, ns_vend_r, fc_flags_r, fc_vend_r, cfg_flags_r, zn_flags_r;
   logic [31:0] rx_ns_r, rx_nsv_r, rx_fc_r, rx_fcv_r, rx_cfg_r, rx_zn_r;
   logic [7:0]  rx_unk_r;
   logic [15:0] rx_last_id_r;
   logic [3:0]  rx_seen_r;
   logic        tx_busy_r;
   logic        tx_go;
   logic        rx_clr;
   logic        acc;
   logic [31:0] rd_nxt;
   logic        err_nxt;

   assign acc    = psel & penable;
   assign tx_go  = acc & pwrite & (paddr == scoc_pkg::REG_CTRL) & pwdata[scoc_pkg::CTRL_TX_GO] & ~tx_busy_r;
   assign rx_clr = acc & pwrite & (paddr == scoc_pkg::REG_CTRL) & pwdata[scoc_pkg::CTRL_RX_CLR];

   // Reserved bits are dropped at the write so they go out as zero
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ns_flags_r  <= 32'h0000_0000;
         ns_vend_r   <= 32'h0000_0000;
         fc_flags_r  <= 32'h0000_0000;
         fc_vend_r   <= 32'h0000_0000;
         cfg_flags_r <= 32'h0000_0000;
         zn_flags_r  <= 32'h0000_0000;
      end else if (acc & pwrite) begin
         if (paddr == scoc_pkg::REG_NS_FLAGS) begin
            ns_flags_r <= pwdata & scoc_pkg::NS_MASK; // RULE5 RULE6 RULE21
         end else if (paddr == scoc_pkg::REG_NS_VEND) begin
            ns_vend_r <= pwdata; // RULE7
         end else if (paddr == scoc_pkg::REG_FC_FLAGS) begin
            fc_flags_r <= pwdata & scoc_pkg::FC_MASK; // RULE9
         end else if (paddr == scoc_pkg::REG_FC_VEND) begin
            fc_vend_r <= pwdata; // RULE7
         end else if (paddr == scoc_pkg::REG_CFG_FLAGS) begin
            cfg_flags_r <= pwdata & scoc_pkg::CFG_MASK; // RULE11
         end else if (paddr == scoc_pkg::REG_ZN_FLAGS) begin
            zn_flags_r <= pwdata & scoc_pkg::ZN_MASK; // RULE13 RULE14 RULE15 RULE16 RULE17 RULE18
         end
      end
   end

   always_comb begin
      rd_nxt  = 32'h0000_0000;
      err_nxt = 1'b0;
      if (paddr == scoc_pkg::REG_CTRL) begin
         rd_nxt = {31'h0000_0000, tx_busy_r};
      end else if (paddr == scoc_pkg::REG_NS_FLAGS) begin
         rd_nxt = ns_flags_r;
      end else if (paddr == scoc_pkg::REG_NS_VEND) begin
         rd_nxt = ns_vend_r;
      end else if (paddr == scoc_pkg::REG_FC_FLAGS) begin
         rd_nxt = fc_flags_r;
      end else if (paddr == scoc_pkg::REG_FC_VEND) begin
         rd_nxt = fc_vend_r;
      end else if (paddr == scoc_pkg::REG_CFG_FLAGS) begin
         rd_nxt = cfg_flags_r;
      end else if (paddr == scoc_pkg::REG_ZN_FLAGS) begin
         rd_nxt = zn_flags_r;
      end else if (paddr == scoc_pkg::REG_STATUS) begin
         rd_nxt = {27'h000_0000, tx_busy_r, rx_seen_r};
      end else if (paddr == scoc_pkg::REG_RX_NS) begin
         rd_nxt = rx_ns_r;
      end else if (paddr == scoc_pkg::REG_RX_NSV) begin
         rd_nxt = rx_nsv_r;
      end else if (paddr == scoc_pkg::REG_RX_FC) begin
         rd_nxt = rx_fc_r;
      end else if (paddr == scoc_pkg::REG_RX_FCV) begin
         rd_nxt = rx_fcv_r;
      end else if (paddr == scoc_pkg::REG_RX_CFG) begin
         rd_nxt = rx_cfg_r;
      end else if (paddr == scoc_pkg::REG_RX_ZN) begin
         rd_nxt = rx_zn_r;
      end else if (paddr == scoc_pkg::REG_RX_UNK) begin
         rd_nxt = {24'h00_0000, rx_unk_r};
      end else if (paddr == scoc_pkg::REG_RX_LAST) begin
         rd_nxt = {16'h0000, rx_last_id_r};
      end else begin
         err_nxt = 1'b1;
      end
   end

   // Registered answer: pready in the first cycle of the access phase
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & err_nxt;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_nxt : 32'h0000_0000;
      end
   end

   // ****************************************
   // Transmit: four objects, 12 bytes each
   // ****************************************
   logic [1:0] tx_obj_r;
   logic [3:0] tx_idx_r;
   logic [7:0] tx_byte;
   logic [31:0] w0, w1;
   logic [7:0] t_type, t_sub;

   always_comb begin
      t_type = scoc_pkg::NS_TYPE;
      t_sub  = scoc_pkg::NS_SUB;
      w0     = ns_flags_r;
      w1     = ns_vend_r;
      case (scoc_pkg::scoc_obj_type'(tx_obj_r))
         scoc_pkg::OBJ_NS: begin
            t_type = scoc_pkg::NS_TYPE; // RULE4
            t_sub  = scoc_pkg::NS_SUB;
            w0     = ns_flags_r;
            w1     = ns_vend_r;
         end
         scoc_pkg::OBJ_FC: begin
            t_type = scoc_pkg::FC_TYPE; // RULE8
            t_sub  = scoc_pkg::FC_SUB;
            w0     = fc_flags_r;
            w1     = fc_vend_r;
         end
         scoc_pkg::OBJ_CFG: begin
            t_type = scoc_pkg::CFG_TYPE; // RULE10
            t_sub  = scoc_pkg::CFG_SUB;
            w0     = cfg_flags_r;
            w1     = 32'h0000_0000;
         end
         default: begin
            t_type = scoc_pkg::ZN_TYPE; // RULE12
            t_sub  = scoc_pkg::ZN_SUB;
            w0     = zn_flags_r;
            w1     = 32'h0000_0000;
         end
      endcase
      case (tx_idx_r)
         4'h0: tx_byte = t_type; // RULE1
         4'h1: tx_byte = t_sub;
         4'h2: tx_byte = scoc_pkg::RESV_BYTE; // RULE21
         4'h3: tx_byte = scoc_pkg::ONE_ENTRY; // RULE2
         4'h4: tx_byte = w0[31:24]; // RULE21
         4'h5: tx_byte = w0[23:16];
         4'h6: tx_byte = w0[15:8];
         4'h7: tx_byte = w0[7:0];
         4'h8: tx_byte = w1[31:24];
         4'h9: tx_byte = w1[23:16];
         4'ha: tx_byte = w1[15:8];
         default: tx_byte = w1[7:0];
      endcase
   end

   logic tx_adv;
   logic obj_end;
   logic tx_load;
   assign tx_adv  = tx_valid & tx_ready;
   assign obj_end = (tx_idx_r == scoc_pkg::OBJ_BYTES - 4'h1);
   // Load only into an empty or draining slot, so a held byte is never sent twice
   assign tx_load = tx_busy_r & ~(tx_valid & tx_last) & (~tx_valid | tx_ready);
   // Objects only; enclosing payload words are added upstream RULE3 RULE19 RULE20

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tx_busy_r <= 1'b0;
         tx_obj_r  <= 2'h0;
         tx_idx_r  <= 4'h0;
      end else if (tx_go) begin
         tx_busy_r <= 1'b1;
         tx_obj_r  <= 2'h0;
         tx_idx_r  <= 4'h0;
      end else if (tx_load) begin
         tx_idx_r <= obj_end ? 4'h0 : tx_idx_r + 4'h1;
         if (obj_end) begin
            tx_obj_r <= tx_obj_r + 2'h1;
         end
      end else if (tx_adv & tx_last) begin
         tx_busy_r <= 1'b0;
      end
   end

   // Byte outputs registered; next byte loaded while the current is taken
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tx_data  <= 8'h00;
         tx_valid <= 1'b0;
         tx_last  <= 1'b0;
      end else if (tx_load) begin
         tx_valid <= 1'b1;
         tx_data  <= tx_byte;
         tx_last  <= obj_end & (tx_obj_r == 2'h3); // RULE2
      end else if (tx_adv) begin
         tx_valid <= 1'b0;
         tx_last  <= 1'b0;
      end
   end

   // ****************************************
   // Receive: walk objects by entry count
   // ****************************************
   logic [7:0]  rx_type_r, rx_sub_r, rx_cnt_r;
   logic [1:0]  rx_hdr_r;
   logic        rx_in_ent_r;
   logic [2:0]  rx_bpos_r;
   logic        rx_first_ent_r;
   logic [63:0] rx_ent_r;
   logic [63:0] ent_full;
   logic        rx_take;

   assign rx_take  = rx_valid & rx_ready;
   assign ent_full = {rx_ent_r[55:0], rx_data};

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rx_ready <= 1'b0;
      end else begin
         rx_ready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rx_hdr_r       <= 2'h0;
         rx_in_ent_r    <= 1'b0;
         rx_bpos_r      <= 3'h0;
         rx_type_r      <= 8'h00;
         rx_sub_r       <= 8'h00;
         rx_cnt_r       <= 8'h00;
         rx_first_ent_r <= 1'b0;
         rx_ent_r       <= 64'h0000_0000_0000_0000;
      end else if (rx_take & rx_last) begin
         rx_hdr_r    <= 2'h0;
         rx_in_ent_r <= 1'b0;
         rx_bpos_r   <= 3'h0;
      end else if (rx_take & ~rx_in_ent_r) begin
         rx_hdr_r <= rx_hdr_r + 2'h1; // RULE1
         if (rx_hdr_r == 2'h0) begin
            rx_type_r <= rx_data;
         end else if (rx_hdr_r == 2'h1) begin
            rx_sub_r <= rx_data;
         end else if (rx_hdr_r == 2'h3) begin
            rx_cnt_r       <= rx_data; // RULE22
            rx_in_ent_r    <= (rx_data != 8'h00);
            rx_first_ent_r <= 1'b1;
            rx_bpos_r      <= 3'h0;
         end
      end else if (rx_take) begin
         rx_ent_r  <= ent_full;
         rx_bpos_r <= rx_bpos_r + 3'h1; // RULE2
         if (rx_bpos_r == scoc_pkg::ENT_LAST) begin
            rx_first_ent_r <= 1'b0;
            rx_cnt_r       <= rx_cnt_r - 8'h01;
            if (rx_cnt_r == 8'h01) begin
               rx_in_ent_r <= 1'b0; // RULE22
            end
         end
      end
   end

   logic ent_done;
   logic hdr_done;
   logic id_known;
   assign ent_done = rx_take & rx_in_ent_r & rx_first_ent_r & (rx_bpos_r == scoc_pkg::ENT_LAST);
   assign hdr_done = rx_take & ~rx_last & ~rx_in_ent_r & (rx_hdr_r == 2'h3);
   assign id_known = ({rx_type_r, rx_sub_r} == {scoc_pkg::NS_TYPE, scoc_pkg::NS_SUB})
                   | ({rx_type_r, rx_sub_r} == {scoc_pkg::FC_TYPE, scoc_pkg::FC_SUB})
                   | ({rx_type_r, rx_sub_r} == {scoc_pkg::CFG_TYPE, scoc_pkg::CFG_SUB})
                   | ({rx_type_r, rx_sub_r} == {scoc_pkg::ZN_TYPE, scoc_pkg::ZN_SUB});

   // Only the first entry of a known object carries its flag words
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rx_ns_r      <= 32'h0000_0000;
         rx_nsv_r     <= 32'h0000_0000;
         rx_fc_r      <= 32'h0000_0000;
         rx_fcv_r     <= 32'h0000_0000;
         rx_cfg_r     <= 32'h0000_0000;
         rx_zn_r      <= 32'h0000_0000;
         rx_unk_r     <= 8'h00;
         rx_seen_r    <= 4'h0;
         rx_last_id_r <= 16'h0000;
      end else begin
         // Clear first, so a set in the same cycle wins
         if (rx_clr) begin
            rx_seen_r <= 4'h0;
            rx_unk_r  <= 8'h00;
         end
         if (ent_done) begin
            rx_last_id_r <= {rx_type_r, rx_sub_r};
            if (rx_type_r == scoc_pkg::NS_TYPE && rx_sub_r == scoc_pkg::NS_SUB) begin
               rx_ns_r      <= ent_full[63:32] & scoc_pkg::NS_MASK; // RULE4 RULE21
               rx_nsv_r     <= ent_full[31:0]; // RULE7
               rx_seen_r[0] <= 1'b1;
            end else if (rx_type_r == scoc_pkg::FC_TYPE && rx_sub_r == scoc_pkg::FC_SUB) begin
               rx_fc_r      <= ent_full[63:32] & scoc_pkg::FC_MASK; // RULE8
               rx_fcv_r     <= ent_full[31:0];
               rx_seen_r[1] <= 1'b1;
            end else if (rx_type_r == scoc_pkg::CFG_TYPE && rx_sub_r == scoc_pkg::CFG_SUB) begin
               rx_cfg_r     <= ent_full[63:32] & scoc_pkg::CFG_MASK; // RULE10
               rx_seen_r[2] <= 1'b1;
            end else if (rx_type_r == scoc_pkg::ZN_TYPE && rx_sub_r == scoc_pkg::ZN_SUB) begin
               rx_zn_r      <= ent_full[63:32] & scoc_pkg::ZN_MASK; // RULE12
               rx_seen_r[3] <= 1'b1;
            end
         end
         // Counted at the header, so an object without entries is flagged too
         if (hdr_done & ~id_known & (rx_unk_r != 8'hff)) begin
            rx_unk_r <= rx_unk_r + 8'h01; // RULE22
         end
      end
   end
endmodule : scoc_codec

/* dv/scoc_sva.sv */
// Checker: bus timing and outgoing object layout of the capability codec
`timescale 1ns/1ns
module scoc_sva (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_valid,
   input wire logic        tx_last,
   input wire logic        tx_ready
);
   // ****************************************
   // Byte position within the outgoing frame
   // ****************************************
   logic       tk;
   logic [5:0] pos_r;
   assign tk = tx_valid & tx_ready;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pos_r <= 6'h00;
      end else if (tk) begin
         pos_r <= tx_last ? 6'h00 : pos_r + 6'h01;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_apb_answer; psel && !penable |=> pready; endproperty
   property p_ready_pulse; pready |=> !pready; endproperty
   property p_rd_zero; !pready |-> prdata == 32'h0000_0000; endproperty
   property p_err; pslverr |-> pready && psel && penable; endproperty
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
   property p_ns_id; tk && pos_r < 6'h02 |-> tx_data == (pos_r == 6'h00 ? 8'hfc : 8'h02); endproperty
   property p_fc_id; tk && pos_r inside {6'h0c, 6'h0d} |-> tx_data == (pos_r == 6'h0c ? 8'hfd : 8'h00); endproperty
   property p_cfg_id; tk && pos_r inside {6'h18, 6'h19} |-> tx_data == (pos_r == 6'h18 ? 8'hfa : 8'h01); endproperty
   property p_zn_id; tk && pos_r inside {6'h24, 6'h25} |-> tx_data == (pos_r == 6'h24 ? 8'hfa : 8'h03); endproperty
   property p_hdr; tk && pos_r inside {6'h02, 6'h0e, 6'h1a, 6'h26} |-> tx_data == 8'h00; endproperty
   property p_cnt; tk && pos_r inside {6'h03, 6'h0f, 6'h1b, 6'h27} |-> tx_data == 8'h01; endproperty
   property p_resv; tk && (pos_r inside {[6'h20:6'h23]} || pos_r > 6'h2b) |-> tx_data == 8'h00; endproperty
   property p_last; tk |-> tx_last == (pos_r == 6'h2f); endproperty
   property p_ns_resv; tk && pos_r inside {[6'h04:6'h07]} |-> (tx_data & (pos_r == 6'h07 ? 8'he0 : 8'hff)) == 8'h00;
   endproperty
   property p_zn_resv; tk && pos_r inside {[6'h28:6'h2a]} |-> (tx_data & (pos_r == 6'h2a ? 8'hfc : 8'hff)) == 8'h00;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("no pready after setup");
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   a_rd_zero: assert property (p_rd_zero) else $error("prdata nonzero outside answer");
   a_err: assert property (p_err) else $error("pslverr outside access");
   a_hold: assert property (p_hold) else $error("byte changed before taken");
   a_ns_id: assert property (p_ns_id) else $error("name server id wrong");
   a_fc_id: assert property (p_fc_id) else $error("controller id wrong");
   a_cfg_id: assert property (p_cfg_id) else $error("config server id wrong");
   a_zn_id: assert property (p_zn_id) else $error("zone server id wrong");
   a_cnt: assert property (p_cnt) else $error("entry count byte wrong");
   a_hdr: assert property (p_hdr) else $error("header reserved byte not zero");
   a_resv: assert property (p_resv) else $error("reserved word not zero");
   a_last: assert property (p_last) else $error("frame end misplaced");
   a_ns_resv: assert property (p_ns_resv) else $error("name server reserved bits set");
   a_zn_resv: assert property (p_zn_resv) else $error("zoning reserved bits set");
   c_hdr: cover property (tk && pos_r == 6'h02);
   c_frame: cover property (tk && tx_last);
   c_err: cover property (pslverr);
   c_read: cover property (pready && !pwrite);
endmodule : scoc_sva
bind scoc_codec scoc_sva u_sva (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
   .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));

/* dv/scoc_peer.sv */
// Partner model: peer controller that sinks and sources capability objects
`timescale 1ns/1ns
module scoc_peer (
   input wire logic       sys_clk,
   input wire logic [7:0] tx_data,
   input wire logic       tx_valid,
   input wire logic       tx_last,
   output logic           tx_ready,
   output logic [7:0]     rx_data,
   output logic           rx_valid,
   output logic           rx_last,
   input wire logic       rx_ready
);
   logic [7:0] got[$];
   logic       lastq[$];
   logic       slow = 1'b0;
   int         hung = 0;
   initial begin
      tx_ready = 1'b0;
      rx_data = 8'h00;
      rx_valid = 1'b0;
      rx_last = 1'b0;
   end
   // Slow mode stalls the sink about a third of the time
   always @(posedge sys_clk) begin
      if (tx_valid && tx_ready) begin
         got.push_back(tx_data);
         lastq.push_back(tx_last);
      end
      tx_ready <= slow ? (($urandom % 3) != 0) : 1'b1;
   end
   task automatic send_byte(input logic [7:0] b, input logic last);
      int n;
      rx_data  <= b;
      rx_valid <= 1'b1;
      rx_last  <= last;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (rx_ready !== 1'b1 && n < 40);
      if (rx_ready !== 1'b1) hung++;
   endtask : send_byte
   // Released line shows the inverse, never a stale copy
   task automatic rx_idle();
      rx_valid <= 1'b0;
      rx_last  <= 1'b0;
      rx_data  <= ~rx_data;
   endtask : rx_idle
   task automatic send_obj(input logic [7:0] ty, input logic [7:0] sb, input logic [7:0] cnt, input logic [63:0] ent);
      send_byte(ty, 1'b0);
      send_byte(sb, 1'b0);
      send_byte(8'h00, 1'b0);
      send_byte(cnt, 1'b0);
      for (int k = 0; k < cnt; k++) begin
         for (int i = 7; i >= 0; i--) send_byte(ent[i*8 +: 8], 1'b0);
      end
   endtask : send_obj
endmodule : scoc_peer

/* dv/tb.sv */
// Testbench: register, transmit and receive checks of the capability codec
`timescale 1ns/1ns
module tb;
   logic         sys_clk = 1'b0;
   logic         reset = 1'b1;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0000_0000;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic [7:0]   tx_data;
   logic         tx_valid;
   logic         tx_last;
   logic         tx_ready;
   logic [7:0]   rx_data;
   logic         rx_valid;
   logic         rx_last;
   logic         rx_ready;
   int           bad_count = 0;
   int           compares = 0;
   logic [31:0]  v[6];
   logic [31:0]  q;
   logic         e;
   logic [383:0] fr;
   // Usable bits per flag word, vendor words pass whole
   localparam logic [31:0] MSK[6] = '{32'h0000_001f, 32'hffff_ffff, 32'h0000_0001, 32'hffff_ffff,
                                      32'h0000_000f, 32'h0000_03ff};
   always #4 sys_clk = ~sys_clk;
   scoc_codec dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_last(rx_last), .rx_ready(rx_ready));
   scoc_peer peer (.sys_clk(sys_clk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready));
   task automatic tally_and_finish();
      bad_count += peer.hung;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) begin
         bad_count++;
         tally_and_finish();
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   function automatic logic [383:0] exp_frame();
      exp_frame = {32'hfc02_0001, v[0] & MSK[0], v[1], 32'hfd00_0001, v[2] & MSK[2], v[3],
                   32'hfa01_0001, v[4] & MSK[4], 32'h0000_0000, 32'hfa03_0001, v[5] & MSK[5], 32'h0000_0000};
   endfunction : exp_frame
   initial begin
      q = $urandom(80);
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      for (int p = 0; p < 2; p++) begin
         peer.slow = p[0];
         for (int i = 0; i < 6; i++) begin
            v[i] = p ? $urandom : 32'hffff_ffff;
            apb(1'b1, 8'h04 + 8'(4 * i), v[i]);
         end
         for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'h04 + 8'(4 * i), 32'h0000_0000);
            chk(q, v[i] & MSK[i]);
         end
         peer.got.delete();
         peer.lastq.delete();
         apb(1'b1, scoc_pkg::REG_CTRL, 32'h0000_0001);
         apb(1'b1, scoc_pkg::REG_CTRL, 32'h0000_0001);
         apb(1'b0, scoc_pkg::REG_STATUS, 32'h0000_0000);
         chk(q & 32'h0000_0010, 32'h0000_0010);
         for (int n = 0; n < 3000 && peer.got.size() < 48; n++) @(posedge sys_clk);
         repeat (60) @(posedge sys_clk);
         chk(32'(peer.got.size()), 32'h0000_0030);
         fr = exp_frame();
         for (int i = 0; i < 48 && i < peer.got.size(); i++) begin
            chk({24'h00_0000, peer.got[i]}, {24'h00_0000, fr[383 - 8 * i -: 8]});
            chk({31'h0000_0000, peer.lastq[i]}, {31'h0000_0000, i == 47});
         end
         $display("test transmit pass %0d done", p);
      end
      peer.send_obj(8'he0, 8'h05, 8'h02, 64'hfc02_0001_fd00_0001);
      peer.send_obj(8'hfa, 8'h07, 8'h00, 64'h0000_0000_0000_0000);
      peer.send_obj(8'hfc, 8'h02, 8'h01, {v[0], v[1]});
      peer.send_obj(8'hfd, 8'h00, 8'h01, {v[2], v[3]});
      peer.send_obj(8'hfa, 8'h01, 8'h01, {v[4], 32'h0000_0000});
      peer.send_obj(8'hfa, 8'h03, 8'h01, {v[5], 32'h0000_0000});
      peer.rx_idle();
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'h20 + 8'(4 * i), 32'h0000_0000);
         chk(q, v[i] & MSK[i]);
      end
      apb(1'b0, scoc_pkg::REG_RX_UNK, 32'h0000_0000);
      chk(q, 32'h0000_0002);
      apb(1'b0, scoc_pkg::REG_STATUS, 32'h0000_0000);
      chk(q, 32'h0000_000f);
      apb(1'b0, scoc_pkg::REG_RX_LAST, 32'h0000_0000);
      chk(q, 32'h0000_fa03);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk({q[30:0], e}, 32'h0000_0001);
      apb(1'b1, scoc_pkg::REG_CTRL, 32'h0000_0002);
      apb(1'b0, scoc_pkg::REG_STATUS, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      $display("test receive done");
      peer.send_obj(8'hfd, 8'h00, 8'h00, 64'h0000_0000_0000_0000);
      peer.send_byte(8'h5a, 1'b0);
      peer.send_byte(8'ha5, 1'b1);
      peer.send_obj(8'hfc, 8'h02, 8'h01, {~v[0], v[1]});
      peer.rx_idle();
      apb(1'b0, scoc_pkg::REG_RX_NS, 32'h0000_0000);
      chk(q, ~v[0] & MSK[0]);
      apb(1'b0, scoc_pkg::REG_RX_FC, 32'h0000_0000);
      chk(q, v[2] & MSK[2]);
      $display("test abort done");
      tally_and_finish();
   end
endmodule : tb
